// File: route_ctrl_pkg.sv
// shared constants and carrier types for the packet routing control block
package route_ctrl_pkg;

    // ------------------------------------------------------------
    // port geometry and timing
    // ------------------------------------------------------------
    localparam int NUM_PORTS = 4;
    localparam int PORT_W = 2;
    localparam int CLK_HZ = 10000000;
    localparam int TIMEOUT_US = 1000;
    localparam int TIMEOUT_CYCLES = TIMEOUT_US * (CLK_HZ / 1000000);
    localparam int TIMER_W = 24;

    // ------------------------------------------------------------
    // control word field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_TIMEOUT_EN_BIT = 0;
    localparam int CTRL_SELF_ADDR_BIT = 1;
    localparam int CTRL_START_REQ_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // per-input request presented by an input port once its header is decoded
    typedef struct packed {
        logic valid;
        logic highPri;
        logic cfgReply;
        logic [NUM_PORTS-1:0] destSet;
    } route_req_type;

    // per-output port status from the output link or FIFO
    typedef struct packed {
        logic running;
        logic credit;
        logic isLink;
    } out_status_type;

endpackage

// File: port_watchdog.sv
// per-input stall watchdog counter
`timescale 1ns/1ps
module port_watchdog #(
    parameter int TIMER_W = 24
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // control
    input wire logic enable,
    input wire logic kick,
    input wire logic stop,
    input wire logic [TIMER_W-1:0] limit,
    // result
    output logic expired
);

    logic [TIMER_W-1:0] count;
    logic [TIMER_W-1:0] next_count;
    logic running;
    logic next_running;

    // restart on activity, halt on stop, count while armed
    always_comb begin
        next_count = count;
        next_running = running;
        if (!enable || stop) begin
            next_running = 1'b0;
            next_count = '0;
        end else if (kick || !running) begin
            // arming on enable lets a waiting packet be timed with no character
            next_running = 1'b1;
            next_count = '0;
        end else if (running && count != limit) begin
            next_count = count + 1'b1;
        end
    end

    // counter registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
            running <= 1'b0;
        end else begin
            count <= next_count;
            running <= next_running;
        end
    end

    assign expired = running && (count == limit) && !kick && !stop;

endmodule

// File: packet_route_control.sv
// routing control: group selection, arbitration, loop-back check, stall spill
// How it works
// - a group packet takes any free and ready member as soon as one exists
// - among several free ready members the lowest numbered port is chosen
// - group packets arbitrate under the same rules as all others
// - busy or not running members are skipped
// - with start on request and no free ready member, all not-running members are asked to start
// - the loop-back permit decides if a packet may leave via its arrival port
// - without permit, self-addressed packets are discarded and an address error flagged
// - configuration replies may always leave through their arrival port
// - control bit 0 selects stall-timeout mode, clear selects indefinite wait
// - indefinite wait mode never discards on timeout for busy outputs
// - waiting on a non-started link port is limited to the timeout
// - in indefinite wait mode, with a running group member, the packet waits without limit
// - watchdog restarts per character, stops after end of packet
// - timeout mode also clears packets waiting on ungranted outputs
// - on expiry the output gets an error end and the input is spilled
// - a pending error end is held until the output can accept
// - output blocked when no transmit credit or external FIFO full
// - equal priority requesters granted round robin after last owner
// - high priority requesters always beat low priority ones
`timescale 1ns/1ps
module packet_route_control #(
    parameter int NUM_PORTS = route_ctrl_pkg::NUM_PORTS,
    parameter int PORT_W = route_ctrl_pkg::PORT_W,
    parameter int TIMER_W = route_ctrl_pkg::TIMER_W,
    parameter logic [TIMER_W-1:0] TIMEOUT_CYCLES = TIMER_W'(route_ctrl_pkg::TIMEOUT_CYCLES)
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // mode control
    input wire logic timeoutEnable,
    input wire logic selfAddrEnable,
    input wire logic startOnRequest,
    // input side
    input wire route_ctrl_pkg::route_req_type [NUM_PORTS-1:0] routeReq,
    input wire logic [NUM_PORTS-1:0] inCharValid,
    input wire logic [NUM_PORTS-1:0] inCharEop,
    output logic [NUM_PORTS-1:0] inGranted,
    output logic [NUM_PORTS-1:0] inSpill,
    output logic [NUM_PORTS-1:0] inDiscard,
    output logic [NUM_PORTS-1:0] addrError,
    // output side
    input wire route_ctrl_pkg::out_status_type [NUM_PORTS-1:0] outStatus,
    output logic [NUM_PORTS-1:0] outStartReq,
    output logic [NUM_PORTS-1:0] outEepInsert,
    output logic [NUM_PORTS*PORT_W-1:0] outOwner
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        IN_IDLE  = 3'b001,
        IN_XFER  = 3'b010,
        IN_SPILL = 3'b100
    } in_state_type;

    in_state_type inState [NUM_PORTS];
    in_state_type next_inState [NUM_PORTS];
    logic [PORT_W-1:0] inDest [NUM_PORTS];
    logic [PORT_W-1:0] next_inDest [NUM_PORTS];
    logic [NUM_PORTS-1:0] outBusy;
    logic [NUM_PORTS-1:0] next_outBusy;
    logic [PORT_W-1:0] lastOwner [NUM_PORTS];
    logic [PORT_W-1:0] next_lastOwner [NUM_PORTS];
    logic [NUM_PORTS-1:0] eepPending;
    logic [NUM_PORTS-1:0] next_eepPending;
    logic [NUM_PORTS-1:0] next_inGranted;
    logic [NUM_PORTS-1:0] next_inSpill;
    logic [NUM_PORTS-1:0] next_inDiscard;
    logic [NUM_PORTS-1:0] next_addrError;
    logic [NUM_PORTS-1:0] next_outEepInsert;
    logic [NUM_PORTS-1:0] next_outStartReq;

    // watchdog hooks
    logic [NUM_PORTS-1:0] wdKick;
    logic [NUM_PORTS-1:0] wdStop;
    logic [NUM_PORTS-1:0] wdEnable;
    logic [NUM_PORTS-1:0] wdExpired;

    // ------------------------------------------------------------
    // output readiness
    // ------------------------------------------------------------
    logic [NUM_PORTS-1:0] outReady;
    logic [NUM_PORTS-1:0] outRunning;

    // an output can take data only when running and holding credit or FIFO room
    always_comb begin
        for (int o = 0; o < NUM_PORTS; o++) begin
            outRunning[o] = outStatus[o].running;
            outReady[o] = outStatus[o].running && outStatus[o].credit;
        end
    end

    // ------------------------------------------------------------
    // per input watchdogs
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_wd
            port_watchdog #(
                .TIMER_W(TIMER_W)
            ) u_wd (
                .core_clk(core_clk),
                .nrst(nrst),
                .enable(wdEnable[gi]),
                .kick(wdKick[gi]),
                .stop(wdStop[gi]),
                .limit(TIMEOUT_CYCLES),
                .expired(wdExpired[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // helper: rotating priority pick after the last owner
    // ------------------------------------------------------------
    function automatic logic [NUM_PORTS-1:0] rr_pick(
        input logic [NUM_PORTS-1:0] req,
        input logic [PORT_W-1:0] last
    );
        logic [NUM_PORTS-1:0] pick;
        logic found;
        int idx;
        pick = '0;
        found = 1'b0;
        for (int k = 1; k <= NUM_PORTS; k++) begin
            idx = (int'(last) + k) % NUM_PORTS;
            if (!found && req[idx]) begin
                pick[idx] = 1'b1;
                found = 1'b1;
            end
        end
        return pick;
    endfunction

    // ------------------------------------------------------------
    // routing, arbitration, watchdog control and spill
    // ------------------------------------------------------------
    logic [NUM_PORTS-1:0] cand [NUM_PORTS];
    logic [NUM_PORTS-1:0] target [NUM_PORTS];
    logic [NUM_PORTS-1:0] reqHi [NUM_PORTS];
    logic [NUM_PORTS-1:0] reqLo [NUM_PORTS];
    logic [NUM_PORTS-1:0] grantTo [NUM_PORTS];
    logic [NUM_PORTS-1:0] freeNow;
    logic [NUM_PORTS-1:0] selfBlocked;
    logic [NUM_PORTS-1:0] anyRunning;
    logic [NUM_PORTS-1:0] wantsStart;
    logic found;

    always_comb begin
        freeNow = outReady & ~outBusy;
        next_outStartReq = '0;
        found = 1'b0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            // loop-back check, replies always pass
            selfBlocked[i] = routeReq[i].valid && !selfAddrEnable && !routeReq[i].cfgReply
                && routeReq[i].destSet[i] && ($countones(routeReq[i].destSet) == 1);
            cand[i] = (inState[i] == IN_IDLE && routeReq[i].valid && !selfBlocked[i])
                ? routeReq[i].destSet : '0;
            if (!selfAddrEnable && !routeReq[i].cfgReply) begin
                cand[i][i] = 1'b0;
            end
            anyRunning[i] = |(cand[i] & outRunning);
            wantsStart[i] = |cand[i] && !(|(cand[i] & freeNow));
            if (startOnRequest && wantsStart[i]) begin
                next_outStartReq = next_outStartReq | (cand[i] & ~outRunning);
            end
            // lowest numbered free ready member, busy or stopped members skipped
            target[i] = '0;
            found = 1'b0;
            for (int o = 0; o < NUM_PORTS; o++) begin
                if (!found && cand[i][o] && freeNow[o]) begin
                    target[i][o] = 1'b1;
                    found = 1'b1;
                end
            end
        end
        // same arbitration for every packet, group or single
        for (int o = 0; o < NUM_PORTS; o++) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                reqHi[o][i] = target[i][o] && routeReq[i].highPri;
                reqLo[o][i] = target[i][o] && !routeReq[i].highPri;
            end
            grantTo[o] = (|reqHi[o]) ? rr_pick(reqHi[o], lastOwner[o])
                : rr_pick(reqLo[o], lastOwner[o]);
        end
    end

    // input and output state transitions
    always_comb begin
        next_outBusy = outBusy;
        next_eepPending = eepPending;
        next_inGranted = '0;
        next_inSpill = '0;
        next_inDiscard = '0;
        next_addrError = '0;
        next_outEepInsert = '0;
        wdKick = '0;
        wdStop = '0;
        wdEnable = '0;
        for (int o = 0; o < NUM_PORTS; o++) begin
            next_lastOwner[o] = lastOwner[o];
            // pending error end goes out once the port can take data
            if (eepPending[o] && outReady[o]) begin
                next_outEepInsert[o] = 1'b1;
                next_eepPending[o] = 1'b0;
                next_outBusy[o] = 1'b0;
            end
        end
        for (int i = 0; i < NUM_PORTS; i++) begin
            next_inState[i] = inState[i];
            next_inDest[i] = inDest[i];
            case (inState[i])
                IN_IDLE: begin
                    // waiting packets are watched in timeout mode, or when no
                    // candidate link is running in wait mode
                    wdEnable[i] = routeReq[i].valid && (timeoutEnable
                        || !anyRunning[i]);
                    wdKick[i] = routeReq[i].valid && !wdExpired[i] && 1'b0;
                    if (selfBlocked[i]) begin
                        next_addrError[i] = 1'b1;
                        next_inState[i] = IN_SPILL;
                        next_inSpill[i] = 1'b1;
                        wdStop[i] = 1'b1;
                    end else if (wdExpired[i]) begin
                        next_inState[i] = IN_SPILL;
                        next_inSpill[i] = 1'b1;
                    end
                    for (int o = 0; o < NUM_PORTS; o++) begin
                        if (grantTo[o][i] && !selfBlocked[i] && !wdExpired[i]) begin
                            next_inState[i] = IN_XFER;
                            next_inDest[i] = PORT_W'(o);
                            next_outBusy[o] = 1'b1;
                            next_lastOwner[o] = PORT_W'(i);
                            next_inGranted[i] = 1'b1;
                            wdStop[i] = 1'b1;
                        end
                    end
                end
                IN_XFER: begin
                    next_inGranted[i] = 1'b1;
                    wdEnable[i] = timeoutEnable;
                    wdKick[i] = inCharValid[i] && !inCharEop[i];
                    wdStop[i] = inCharValid[i] && inCharEop[i];
                    if (inCharValid[i] && inCharEop[i]) begin
                        next_inState[i] = IN_IDLE;
                        next_outBusy[inDest[i]] = 1'b0;
                        next_inGranted[i] = 1'b0;
                    end else if (wdExpired[i]) begin
                        // terminate output with an error end, drain the input
                        next_inGranted[i] = 1'b0;
                        next_inSpill[i] = 1'b1;
                        next_inState[i] = IN_SPILL;
                        if (outReady[inDest[i]]) begin
                            next_outEepInsert[inDest[i]] = 1'b1;
                            next_outBusy[inDest[i]] = 1'b0;
                        end else begin
                            next_eepPending[inDest[i]] = 1'b1;
                        end
                    end
                end
                IN_SPILL: begin
                    // discard up to and including the end of packet
                    next_inSpill[i] = 1'b1;
                    if (inCharValid[i] && inCharEop[i]) begin
                        next_inDiscard[i] = 1'b1;
                        next_inState[i] = IN_IDLE;
                        next_inSpill[i] = 1'b0;
                    end
                end
                default: begin
                    next_inState[i] = IN_IDLE;
                end
            endcase
        end
    end

    // state registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                inState[i] <= IN_IDLE;
                inDest[i] <= '0;
                lastOwner[i] <= '0;
            end
            outBusy <= '0;
            eepPending <= '0;
            inGranted <= '0;
            inSpill <= '0;
            inDiscard <= '0;
            addrError <= '0;
            outEepInsert <= '0;
            outStartReq <= '0;
        end else begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                inState[i] <= next_inState[i];
                inDest[i] <= next_inDest[i];
                lastOwner[i] <= next_lastOwner[i];
            end
            outBusy <= next_outBusy;
            eepPending <= next_eepPending;
            inGranted <= next_inGranted;
            inSpill <= next_inSpill;
            inDiscard <= next_inDiscard;
            addrError <= next_addrError;
            outEepInsert <= next_outEepInsert;
            outStartReq <= next_outStartReq;
        end
    end

    // owner map for the output switch
    always_comb begin
        for (int o = 0; o < NUM_PORTS; o++) begin
            outOwner[o*PORT_W +: PORT_W] = lastOwner[o];
        end
    end

endmodule

// File: packet_route_control_checker.sv
// concurrent checks on the routing control ports, bound to the block
`timescale 1ns/1ps
module packet_route_control_checker #(
    parameter int NUM_PORTS = 4,
    parameter int PORT_W = 2,
    parameter int TIMER_W = 24,
    parameter logic [TIMER_W-1:0] TIMEOUT_CYCLES = '0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // mode control
    input wire logic timeoutEnable,
    input wire logic selfAddrEnable,
    input wire logic startOnRequest,
    // input side
    input wire route_ctrl_pkg::route_req_type [NUM_PORTS-1:0] routeReq,
    input wire logic [NUM_PORTS-1:0] inCharValid,
    input wire logic [NUM_PORTS-1:0] inCharEop,
    input wire logic [NUM_PORTS-1:0] inGranted,
    input wire logic [NUM_PORTS-1:0] inSpill,
    input wire logic [NUM_PORTS-1:0] inDiscard,
    input wire logic [NUM_PORTS-1:0] addrError,
    // output side
    input wire route_ctrl_pkg::out_status_type [NUM_PORTS-1:0] outStatus,
    input wire logic [NUM_PORTS-1:0] outStartReq,
    input wire logic [NUM_PORTS-1:0] outEepInsert,
    input wire logic [NUM_PORTS*PORT_W-1:0] outOwner
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------
    // per port relations
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
        a_grant_has_request: assert property ($rose(inGranted[i]) |-> $past(routeReq[i].valid))
            else $error("grant without request");
        a_self_addr_refused: assert property (($rose(routeReq[i].valid) && !selfAddrEnable
            && !routeReq[i].cfgReply && routeReq[i].destSet == NUM_PORTS'(1 << i))
            |-> ##[1:2] addrError[i])
            else $error("self addressed packet not refused");
        a_refused_spills: assert property (addrError[i] |-> !inGranted[i] ##[0:2] inSpill[i])
            else $error("refused packet not spilled");
        a_spill_held: assert property (inSpill[i] && !(inCharValid[i] && inCharEop[i]) |=> inSpill[i])
            else $error("spill ended before end of packet");
        a_discard_pulse: assert property (inDiscard[i] |-> $past(inSpill[i]) ##1 !inDiscard[i])
            else $error("discard not a single pulse after spill");
        a_grant_held: assert property (inGranted[i] && !inCharValid[i] |=> inGranted[i] || inSpill[i])
            else $error("grant lost without end of packet");
        a_wait_no_spill: assert property (!timeoutEnable && inGranted[i] && !inSpill[i] |=> !inSpill[i])
            else $error("spill in indefinite wait mode");
        a_eep_when_ready: assert property (outEepInsert[i] |-> outStatus[i].credit
            || $past(outStatus[i].credit))
            else $error("error end inserted while output blocked");
    end
endmodule

bind packet_route_control packet_route_control_checker #(
    .NUM_PORTS(NUM_PORTS),
    .PORT_W(PORT_W),
    .TIMER_W(TIMER_W),
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) packet_route_control_checker_inst (
    .core_clk(core_clk), .nrst(nrst), .timeoutEnable(timeoutEnable),
    .selfAddrEnable(selfAddrEnable), .startOnRequest(startOnRequest), .routeReq(routeReq),
    .inCharValid(inCharValid), .inCharEop(inCharEop), .inGranted(inGranted),
    .inSpill(inSpill), .inDiscard(inDiscard), .addrError(addrError), .outStatus(outStatus),
    .outStartReq(outStartReq), .outEepInsert(outEepInsert), .outOwner(outOwner)
);

// File: out_port_model.sv
// behavioural model of one output link port seen by the routing control
`timescale 1ns/1ps
module out_port_model #(
    parameter int START_DELAY = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // link control
    input wire logic startReq,
    input wire logic linkOn,
    input wire logic block,
    // status
    output route_ctrl_pkg::out_status_type status
);
    logic started;
    logic next_started;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic run;

    // a start request held long enough brings the link up
    always_comb begin
        next_cnt = (startReq && !started) ? cnt + 4'h1 : 4'h0;
        next_started = started | (cnt == 4'(START_DELAY));
    end

    // state registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 4'h0;
            started <= 1'b0;
        end else begin
            cnt <= next_cnt;
            started <= next_started;
        end
    end

    // no credit when stalled by the far end
    assign run = linkOn | started;
    assign status = '{running: run, credit: run & !block, isLink: 1'b1};
endmodule

// File: packet_route_control_tb_top.sv
// self-checking testbench of the routing control block
`timescale 1ns/1ps
module packet_route_control_tb_top;
    localparam int NP = route_ctrl_pkg::NUM_PORTS;
    localparam int PW = route_ctrl_pkg::PORT_W;
    logic core_clk = 1'b0;
    logic nrst;
    logic timeoutEnable, selfAddrEnable, startOnRequest;
    route_ctrl_pkg::route_req_type [NP-1:0] routeReq;
    route_ctrl_pkg::out_status_type [NP-1:0] outStatus;
    logic [NP-1:0] inCharValid, inCharEop, inGranted, inSpill, inDiscard, addrError;
    logic [NP-1:0] outStartReq, outEepInsert, linkOn, block, prevG;
    logic [NP*PW-1:0] outOwner;
    logic [15:0] q[$];
    logic [3:0] ev[4];
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;

    always #50 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // design and far side ports
    // ------------------------------------------------------------
    packet_route_control #(.TIMEOUT_CYCLES(24'h10)) packet_route_control_inst (
        .core_clk(core_clk), .nrst(nrst), .timeoutEnable(timeoutEnable),
        .selfAddrEnable(selfAddrEnable), .startOnRequest(startOnRequest), .routeReq(routeReq),
        .inCharValid(inCharValid), .inCharEop(inCharEop), .inGranted(inGranted),
        .inSpill(inSpill), .inDiscard(inDiscard), .addrError(addrError), .outStatus(outStatus),
        .outStartReq(outStartReq), .outEepInsert(outEepInsert), .outOwner(outOwner));
    for (genvar o = 0; o < NP; o++) begin : g_out
        out_port_model #(.START_DELAY(4 + 5 * (o % 2))) out_port_model_inst (
            .core_clk(core_clk), .nrst(nrst), .startReq(outStartReq[o]),
            .linkOn(linkOn[o]), .block(block[o]), .status(outStatus[o]));
    end

    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    task automatic compare(logic [15:0] e, logic [15:0] g);
        check_count++;
        if (e !== g) begin
            n_mismatch++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic note(logic [3:0] k, logic [3:0] m);
        q.push_back({4'h0, k, 4'h0, m});
    endtask
    task automatic own(int o, logic [1:0] e);
        @(negedge core_clk);
        compare(16'(e), 16'(outOwner[o*PW +: PW]));
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (q.size() > 0 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        compare(16'h0, 16'(q.size()));
        q.delete();
    endtask

    // events seen at the outputs: grant rise, error end, address error, discard
    always @(negedge core_clk) begin
        if (nrst) begin
            ev[0] = inGranted & ~prevG;
            ev[1] = outEepInsert;
            ev[2] = addrError;
            ev[3] = inDiscard;
            prevG = inGranted;
            for (int k = 0; k < 4; k++) begin
                if (ev[k] !== 4'h0) compare(q.size() ? q.pop_front() : 16'hffff, {4'h0, 4'(k), 4'h0, ev[k]});
            end
        end
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // stimulus tasks
    // ------------------------------------------------------------
    task automatic req(int i, bit h, bit c, logic [3:0] d);
        @(posedge core_clk);
        routeReq[i] <= '{1'b1, h, c, d};
    endtask
    task automatic wt(int i);
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (!(inGranted[i] | inSpill[i] | addrError[i]) && n < 100);
        @(posedge core_clk);
        routeReq[i].valid <= 1'b0;
    endtask
    task automatic dat(int i, int n);
        repeat (n) begin
            @(posedge core_clk);
            inCharValid[i] <= 1'b1;
            @(posedge core_clk);
            inCharValid[i] <= 1'b0;
            repeat ($urandom % 4) @(posedge core_clk);
        end
    endtask
    task automatic eop(int i);
        @(posedge core_clk);
        inCharValid[i] <= 1'b1;
        inCharEop[i] <= 1'b1;
        @(posedge core_clk);
        inCharValid[i] <= 1'b0;
        inCharEop[i] <= 1'b0;
    endtask

    // main sequence
    initial begin
        void'($urandom(32'hf01b8c74));
        {nrst, timeoutEnable, selfAddrEnable, startOnRequest} = 4'h0;
        {routeReq, inCharValid, inCharEop, block, prevG} = '0;
        linkOn = 4'hf;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        @(negedge core_clk);
        compare(16'h0, {inGranted, inSpill, inDiscard, addrError});
        note(0, 4'h8); req(3, 0, 0, 4'h6); wt(3); own(1, 3);
        dat(3, 1 + $urandom % 4); eop(3);
        @(posedge core_clk) linkOn <= 4'hd;
        note(0, 4'h8); req(3, 0, 0, 4'h6); wt(3); own(2, 3); eop(3);
        @(posedge core_clk) linkOn <= 4'hf;
        note(2, 4'h2); note(3, 4'h2); req(1, 0, 0, 4'h2); wt(1);
        repeat (3) @(posedge core_clk);
        eop(1); drain();
        note(0, 4'h2); req(1, 0, 1, 4'h2); wt(1); own(1, 1); eop(1);
        @(posedge core_clk) selfAddrEnable <= 1'b1;
        note(0, 4'h2); req(1, 0, 0, 4'h2); wt(1); own(1, 1); eop(1); drain();
        note(0, 4'h8); note(0, 4'h2);
        @(posedge core_clk);
        routeReq[1] <= '{1'b1, 1'b0, 1'b0, 4'h8};
        routeReq[3] <= '{1'b1, 1'b1, 1'b0, 4'h8};
        wt(3); own(3, 3); eop(3); wt(1); own(3, 1); eop(1); drain();
        note(0, 4'h1); note(0, 4'h2);
        @(posedge core_clk);
        linkOn <= 4'hb;
        routeReq[0] <= '{1'b1, 1'b0, 1'b0, 4'hc};
        routeReq[1] <= '{1'b1, 1'b0, 1'b0, 4'hc};
        wt(0); own(3, 0); eop(0); wt(1); own(3, 1); eop(1); drain();
        @(posedge core_clk) timeoutEnable <= 1'b1;
        note(0, 4'h1); note(1, 4'h1); req(0, 0, 0, 4'h1); wt(0); dat(0, 3);
        compare(16'h0, 16'(inSpill[0]));
        @(posedge core_clk) block[0] <= 1'b1;
        repeat (40) @(negedge core_clk);
        compare(16'h1, 16'(inSpill[0]));
        compare(16'h1, 16'(q.size()));
        @(posedge core_clk) block[0] <= 1'b0;
        repeat (3) @(negedge core_clk);
        note(3, 4'h1); eop(0); drain();
        for (int m = 1; m >= 0; m--) begin
            @(posedge core_clk) timeoutEnable <= m[0];
            req(1, 0, 0, 4'h4);
            repeat (40) @(negedge core_clk);
            compare(16'h1, 16'(inSpill[1]));
            @(posedge core_clk) routeReq[1].valid <= 1'b0;
            note(3, 4'h2); eop(1); drain();
        end
        note(0, 4'h1); req(0, 0, 0, 4'h1); wt(0);
        @(posedge core_clk) linkOn <= 4'h9;
        req(3, 0, 0, 4'h3);
        repeat (40) @(negedge core_clk);
        compare(16'h0, 16'({inSpill[0], inSpill[3]}));
        note(0, 4'h8); eop(0); wt(3); own(0, 3); eop(3); drain();
        @(posedge core_clk);
        startOnRequest <= 1'b1;
        linkOn <= 4'h3;
        req(1, 0, 0, 4'hc);
        repeat (2) @(negedge core_clk);
        compare(16'hc, 16'(outStartReq));
        note(0, 4'h2); wt(1); own(2, 1); eop(1); drain();
        print_verdict();
    end
endmodule
